// ===== include/power_fault_pkg.sv
// shared constants and types of the point-of-load fault manager
// assumes a single 50 MHz system clock and measurements in millivolts
package power_fault_pkg;

    // ***********************************************************
    // timing
    // ***********************************************************
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned HICCUP_MS = 130;
    localparam int unsigned HICCUP_CYC = CLK_HZ / 1000 * HICCUP_MS;

    // ***********************************************************
    // thresholds and reset values
    // ***********************************************************
    localparam logic [7:0] TEMP_TRIP_C = 8'h78;
    localparam logic [7:0] TEMP_RESUME_C = 8'h6E;
    localparam logic [15:0] TRACK_LIMIT_MV = 16'h00FA;
    localparam logic [7:0] OVERVOLT_PCT_MIN = 8'h6E;
    localparam logic [7:0] OVERVOLT_PCT_MAX = 8'h82;
    localparam logic [25:0] PERCENT_SCALE = 26'h0000064;
    localparam logic [25:0] OVERVOLT_FLOOR_X100 = 26'h00186A0;
    localparam logic [15:0] ZERO_MV = 16'h000A;
    localparam logic [4:0] FLAGS_RESET = 5'h1F;
    localparam logic [2:0] DRIVE_HIST_RESET = 3'h0;

    // ***********************************************************
    // types
    // ***********************************************************
    typedef enum logic [2:0] {
        S_OFF = 3'h0,
        S_RAMP_UP = 3'h1,
        S_STEADY = 3'h2,
        S_REG_OFF = 3'h3,
        S_FAST_OFF = 3'h4,
        S_HICCUP = 3'h5,
        S_LATCHED = 3'h6
    } seq_state_type;

    typedef enum logic [2:0] {
        CAUSE_NONE = 3'h0,
        CAUSE_OVERVOLT = 3'h1,
        CAUSE_TRACK = 3'h2,
        CAUSE_OVERCUR = 3'h3,
        CAUSE_OVERTEMP = 3'h4,
        CAUSE_UNDERVOLT = 3'h5,
        CAUSE_GROUP_FAULT = 3'h6,
        CAUSE_GROUP_ERROR = 3'h7
    } cause_type;

    // status flags read 1 while healthy; also used for latching config
    typedef struct packed {
        logic overvoltage_flag;
        logic tracking_flag;
        logic overcurrent_flag;
        logic overtemp_flag;
        logic undervoltage_flag;
    } prot_flags_type;

    typedef struct packed {
        logic [15:0] vout;
        logic [15:0] vset;
        logic [15:0] target;
        logic [15:0] uv_thresh;
    } meas_type;

    typedef struct packed {
        logic pwm_run;
        logic ramp_up;
        logic ramp_down;
        logic ls_force;
    } switch_ctrl_type;

endpackage

// ===== rtl/bit_sync.sv
// two flip-flop synchroniser for asynchronous level inputs
// assumes inputs are slow levels such as an open-drain group line
`timescale 1ns/100ps
`default_nettype none

module bit_sync #(
    parameter int unsigned WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            meta_r <= RESET_VAL;
            dout <= RESET_VAL;
        end else begin
            meta_r <= din;
            dout <= meta_r;
        end
    end

endmodule

`default_nettype wire

// ===== rtl/hiccup_timer.sv
// down counter timing the restart interval after a fault shutdown
// assumes start is a one-cycle pulse from logic on clk_sys
`timescale 1ns/100ps
`default_nettype none

module hiccup_timer
    import power_fault_pkg::*;
#(
    parameter int unsigned CYCLES = HICCUP_CYC
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic start,
    output logic done
);

    localparam int unsigned W = $clog2(CYCLES + 1);

    logic [W-1:0] count_r;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            count_r <= '0;
        end else if (start) begin
            count_r <= W'(CYCLES);
        end else if (count_r != '0) begin
            count_r <= count_r - 1'b1;
        end
    end

    assign done = (count_r == '0) && !start;

endmodule

`default_nettype wire

// ===== rtl/power_fault_manager.sv
// fault manager of a point-of-load converter: detection, turn-off
// type, hiccup restart and group fault line propagation
// assumes measurements and ramp_complete come from logic on clk_sys;
// the group line and group error pins are asynchronous
//
// Operation
// - undervoltage detection armed only in steady state, ignored during ramps
// - output below undervoltage threshold without overcurrent: fault, shutdown, flag 0
// - temperature above 120 C: fault, regular turn-off, flag 0
// - non-latching overtemperature restarts once temperature falls below 110 C
// - during ramp-up only, compare output against ramp target
// - tracking difference above 250 mV: fault, flag 0, fast turn-off
// - tracking disable bit blocks any tracking fault
// - above pre-bias, output over threshold: error, shutdown, flag 0
// - overvoltage error opens high side and closes low side together
// - overvoltage threshold 110 to 130 percent of setpoint, never below 1.0 V
// - undervoltage and overtemperature use ramped regular turn-off
// - group of 1 to 32 units; propagation enabled by config bit
// - faulting unit pulls group line low; low line turns units off
// - propagated fault gives regular turn-off; originator uses its own type
// - propagated error gives fast turn-off; originator keeps low side on
// - non-latching fault retries turn-on every 130 ms until cause clears
// - 130 ms runs from output at zero to next ramp-up
// - overcurrent below undervoltage threshold: fault, flag 0, both switches off
// - latching stays off; restart after 130 ms if cleared or cycled
`timescale 1ns/100ps
`default_nettype none

module power_fault_manager
    import power_fault_pkg::*;
#(
    parameter int unsigned HICCUP_CYCLES = HICCUP_CYC
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire meas_type meas,
    input wire logic [7:0] temp_c,
    input wire logic [7:0] overvolt_pct,
    input wire logic oc_limit_hit,
    input wire logic turn_on_cmd,
    input wire logic ramp_complete,
    input wire prot_flags_type protection_type_config,
    input wire logic track_protect_disable,
    input wire logic propagation_config,
    input wire prot_flags_type status_clear,
    input wire logic group_ok_in,
    input wire logic group_err_in,
    output logic group_ok_out,
    output logic group_ok_oe_n,
    output switch_ctrl_type sw,
    output prot_flags_type protection_status_reg,
    output cause_type shutdown_cause
);

    // ***********************************************************
    // pin synchronisation
    // ***********************************************************
    logic [1:0] pins_s;

    bit_sync #(
        .WIDTH(2),
        .RESET_VAL(2'h1)
    ) u_pin_sync (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .din({group_err_in, group_ok_in}),
        .dout(pins_s)
    );

    // ***********************************************************
    // state
    // ***********************************************************
    seq_state_type state_r;
    seq_state_type state_nxt;
    cause_type cause_r;
    cause_type cause_nxt;
    prot_flags_type flags_r;
    prot_flags_type flags_nxt;
    switch_ctrl_type sw_nxt;
    logic [15:0] prebias_r;
    logic armed_r;
    logic grp_drive_r;
    logic grp_drive_nxt;
    logic [2:0] drive_hist_r;
    logic hiccup_done;

    // ***********************************************************
    // detection
    // ***********************************************************
    wire on_state = (state_r == S_RAMP_UP) || (state_r == S_STEADY);
    wire off_fault_state = (state_r == S_REG_OFF) ||
        (state_r == S_FAST_OFF) || (state_r == S_HICCUP) ||
        (state_r == S_LATCHED);
    // our own release takes the synchroniser depth to be seen
    wire group_low = !pins_s[0] && !grp_drive_r && (drive_hist_r == '0);
    wire group_err = pins_s[1];
    wire at_zero = meas.vout <= ZERO_MV;
    wire temp_hot = temp_c > TEMP_TRIP_C;
    wire temp_cool = temp_c < TEMP_RESUME_C;
    wire below_uv = meas.vout < meas.uv_thresh;
    wire undervolt_trip = (state_r == S_STEADY) && below_uv &&
        !oc_limit_hit;
    wire overcur_trip = on_state && armed_r && oc_limit_hit &&
        below_uv;
    wire [15:0] track_diff = (meas.vout >= meas.target) ?
        meas.vout - meas.target : meas.target - meas.vout;
    wire track_trip = (state_r == S_RAMP_UP) && !track_protect_disable &&
        (track_diff > TRACK_LIMIT_MV);
    wire [7:0] pct_c = (overvolt_pct < OVERVOLT_PCT_MIN) ? OVERVOLT_PCT_MIN :
        (overvolt_pct > OVERVOLT_PCT_MAX) ? OVERVOLT_PCT_MAX :
        overvolt_pct;
    wire [25:0] vset_x_pct = 26'(meas.vset) * 26'(pct_c);
    wire [25:0] overvolt_lim = (vset_x_pct < OVERVOLT_FLOOR_X100) ?
        OVERVOLT_FLOOR_X100 : vset_x_pct;
    wire [25:0] vout_x100 = 26'(meas.vout) * PERCENT_SCALE;
    wire overvolt_trip = on_state && armed_r &&
        (vout_x100 > overvolt_lim);
    wire temp_trip = on_state && temp_hot;
    wire group_trip = on_state && group_low;

    // ***********************************************************
    // cause selection, overvoltage error first, group fault and error last
    // ***********************************************************
    wire trip_any = overvolt_trip || track_trip || overcur_trip ||
        temp_trip || undervolt_trip || group_trip;
    cause_type trip_cause;
    assign trip_cause = overvolt_trip ? CAUSE_OVERVOLT :
        track_trip ? CAUSE_TRACK :
        overcur_trip ? CAUSE_OVERCUR :
        temp_trip ? CAUSE_OVERTEMP :
        undervolt_trip ? CAUSE_UNDERVOLT :
        group_err ? CAUSE_GROUP_ERROR : CAUSE_GROUP_FAULT;
    // regular turn-off for temperature, undervoltage, propagated faults
    wire trip_fast = (trip_cause == CAUSE_OVERVOLT) ||
        (trip_cause == CAUSE_TRACK) || (trip_cause == CAUSE_OVERCUR) ||
        (trip_cause == CAUSE_GROUP_ERROR);
    wire own_cause = (cause_r != CAUSE_NONE) &&
        (cause_r != CAUSE_GROUP_FAULT) && (cause_r != CAUSE_GROUP_ERROR);

    logic cause_latch;
    logic cause_gone;
    logic cause_flag_ok;

    always_comb begin
        cause_latch = 1'b0;
        cause_gone = 1'b1;
        cause_flag_ok = 1'b1;
        case (cause_r)
            CAUSE_OVERVOLT: begin
                cause_latch = protection_type_config.overvoltage_flag;
                cause_flag_ok = flags_r.overvoltage_flag;
            end
            CAUSE_TRACK: begin
                cause_latch = protection_type_config.tracking_flag;
                cause_flag_ok = flags_r.tracking_flag;
            end
            CAUSE_OVERCUR: begin
                cause_latch = protection_type_config.overcurrent_flag;
                cause_gone = !oc_limit_hit;
                cause_flag_ok = flags_r.overcurrent_flag;
            end
            CAUSE_OVERTEMP: begin
                cause_latch = protection_type_config.overtemp_flag;
                cause_gone = temp_cool;
                cause_flag_ok = flags_r.overtemp_flag;
            end
            CAUSE_UNDERVOLT: begin
                cause_latch = protection_type_config.undervoltage_flag;
                cause_flag_ok = flags_r.undervoltage_flag;
            end
            CAUSE_GROUP_FAULT, CAUSE_GROUP_ERROR: begin
                cause_gone = !group_low && (pins_s[0] || grp_drive_r);
            end
            default: begin
                cause_latch = 1'b0;
            end
        endcase
    end

    // non-latching overtemperature resumes without waiting out the timer
    wire temp_quick = (cause_r == CAUSE_OVERTEMP) &&
        !protection_type_config.overtemp_flag && temp_cool &&
        turn_on_cmd;

    // ***********************************************************
    // sequencing
    // ***********************************************************
    always_comb begin
        state_nxt = state_r;
        cause_nxt = cause_r;
        case (state_r)
            S_OFF: begin
                cause_nxt = CAUSE_NONE;
                if (turn_on_cmd && !temp_hot && !group_low) begin
                    state_nxt = S_RAMP_UP;
                end
            end
            S_RAMP_UP, S_STEADY: begin
                if (trip_any) begin
                    cause_nxt = trip_cause;
                    state_nxt = trip_fast ? S_FAST_OFF : S_REG_OFF;
                end else if (!turn_on_cmd) begin
                    state_nxt = S_REG_OFF;
                end else if (state_r == S_RAMP_UP && ramp_complete) begin
                    state_nxt = S_STEADY;
                end
            end
            S_REG_OFF, S_FAST_OFF: begin
                if (at_zero) begin
                    // hiccup interval counts from output at zero
                    state_nxt = (cause_r == CAUSE_NONE) ? S_OFF : S_HICCUP;
                end
            end
            S_HICCUP: begin
                if (temp_quick) begin
                    state_nxt = S_RAMP_UP;
                end else if (hiccup_done) begin
                    if (cause_latch) begin
                        state_nxt = S_LATCHED;
                    end else if (!turn_on_cmd) begin
                        state_nxt = S_OFF;
                    end else if (cause_gone) begin
                        state_nxt = S_RAMP_UP;
                    end
                end
            end
            S_LATCHED: begin
                // turn-on cycling passes through off
                if (!turn_on_cmd) begin
                    state_nxt = S_OFF;
                end else if (cause_gone && cause_flag_ok) begin
                    state_nxt = S_RAMP_UP;
                end
            end
            default: begin
                state_nxt = S_OFF;
            end
        endcase
    end

    wire hiccup_start = (state_nxt == S_HICCUP) && (state_r != S_HICCUP);

    hiccup_timer #(
        .CYCLES(HICCUP_CYCLES)
    ) u_hiccup (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .start(hiccup_start),
        .done(hiccup_done)
    );

    // ***********************************************************
    // flags: a detected condition beats a clear in the same cycle
    // ***********************************************************
    wire restart_done = (state_r == S_RAMP_UP) && (state_nxt == S_STEADY);
    wire [4:0] flag_events = {overvolt_trip, track_trip, overcur_trip,
        temp_hot, undervolt_trip};
    assign flags_nxt = (flags_r | status_clear | {5{restart_done}}) &
        ~flag_events;

    // ***********************************************************
    // switch control and group line
    // ***********************************************************
    wire nxt_on = (state_nxt == S_RAMP_UP) || (state_nxt == S_STEADY);
    assign sw_nxt.pwm_run = nxt_on || (state_nxt == S_REG_OFF);
    assign sw_nxt.ramp_up = state_nxt == S_RAMP_UP;
    assign sw_nxt.ramp_down = state_nxt == S_REG_OFF;
    // high side off and low side on in the same edge
    assign sw_nxt.ls_force = (cause_nxt == CAUSE_OVERVOLT) && !nxt_on &&
        (state_nxt != S_OFF);
    assign grp_drive_nxt = propagation_config && own_cause &&
        off_fault_state && !nxt_on;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= S_OFF;
            cause_r <= CAUSE_NONE;
            flags_r <= FLAGS_RESET;
            sw <= '0;
            grp_drive_r <= 1'b0;
            drive_hist_r <= DRIVE_HIST_RESET;
        end else begin
            state_r <= state_nxt;
            cause_r <= cause_nxt;
            flags_r <= flags_nxt;
            sw <= sw_nxt;
            grp_drive_r <= grp_drive_nxt;
            drive_hist_r <= {drive_hist_r[1:0], grp_drive_r};
        end
    end

    // pre-bias caught while off; over-limit checks armed once exceeded
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            prebias_r <= '0;
            armed_r <= 1'b0;
        end else if (state_r == S_OFF) begin
            prebias_r <= meas.vout;
            armed_r <= 1'b0;
        end else if (on_state && meas.vout > prebias_r) begin
            armed_r <= 1'b1;
        end
    end

    assign group_ok_out = 1'b0;
    assign group_ok_oe_n = !grp_drive_r;
    assign protection_status_reg = flags_r;
    assign shutdown_cause = cause_r;

    // ***********************************************************
    // assertions
    // ***********************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    wire other_trips = overvolt_trip || track_trip || overcur_trip ||
        temp_hot;

    sequence steady_uv_s;
        state_r == S_STEADY && below_uv && !oc_limit_hit && !other_trips;
    endsequence

    sequence own_off_s;
        propagation_config && own_cause && off_fault_state && !nxt_on;
    endsequence

    sequence peer_low_s;
        state_r == S_STEADY && group_low && !other_trips && !below_uv;
    endsequence

    uv_ramp_ignore_a: assert property (
        state_r == S_RAMP_UP && !track_trip &&
        protection_status_reg.undervoltage_flag
        |=> protection_status_reg.undervoltage_flag)
        else $error("undervoltage flag dropped during ramp");

    uv_shutdown_a: assert property (
        steady_uv_s |=> !protection_status_reg.undervoltage_flag &&
        state_r == S_REG_OFF && sw.ramp_down && sw.pwm_run)
        else $error("undervoltage did not give regular turn-off");

    temp_trip_a: assert property (
        temp_hot |=> !protection_status_reg.overtemp_flag)
        else $error("overtemperature flag not cleared");

    temp_resume_a: assert property (
        state_r == S_HICCUP && cause_r == CAUSE_OVERTEMP &&
        !protection_type_config.overtemp_flag && temp_cool && turn_on_cmd
        |=> state_r == S_RAMP_UP && sw.ramp_up)
        else $error("no restart after temperature fell");

    track_fast_a: assert property (
        state_r == S_RAMP_UP && !track_protect_disable && !overvolt_trip &&
        track_diff > TRACK_LIMIT_MV |=> state_r == S_FAST_OFF &&
        !sw.pwm_run && !sw.ls_force && !protection_status_reg.tracking_flag)
        else $error("tracking error not handled");

    track_disable_a: assert property (
        track_protect_disable && protection_status_reg.tracking_flag
        |=> protection_status_reg.tracking_flag)
        else $error("tracking flag dropped while disabled");

    overvolt_clamp_a: assert property (
        overvolt_trip |=> state_r == S_FAST_OFF && !sw.pwm_run &&
        sw.ls_force && !protection_status_reg.overvoltage_flag)
        else $error("overvoltage did not clamp low side");

    group_pull_a: assert property (
        own_off_s |=> !group_ok_oe_n)
        else $error("group line not pulled on own fault");

    peer_off_a: assert property (
        peer_low_s |=> ($past(group_err) ? state_r == S_FAST_OFF :
        state_r == S_REG_OFF) && !sw.ls_force)
        else $error("wrong turn-off type on group line");

    hiccup_hold_a: assert property (
        state_r == S_HICCUP && !hiccup_done && !temp_quick
        |=> state_r == S_HICCUP)
        else $error("left hiccup before interval ended");

    latch_hold_a: assert property (
        state_r == S_LATCHED && turn_on_cmd && !cause_flag_ok
        |=> state_r == S_LATCHED)
        else $error("latched shutdown restarted");

    flag_hold_a: assert property (
        !protection_status_reg.overcurrent_flag &&
        !status_clear.overcurrent_flag && !restart_done
        |=> !protection_status_reg.overcurrent_flag)
        else $error("overcurrent flag released on its own");

endmodule

`default_nettype wire

// ===== test/group_line_model.sv
// group fault line with its pull-up, peer units and power manager
// assumes the unit drives the line open drain, oe_n low pulls
`timescale 1ns/100ps
`default_nettype none
module group_line_model (
    input wire logic unit_out,
    input wire logic unit_oe_n,
    input wire logic peer_pull,
    input wire logic peer_err,
    output logic grp_line,
    output logic grp_err
);
    // pull-up holds the line high unless any party pulls it low
    assign grp_line = (unit_oe_n ? 1'h1 : unit_out) & ~peer_pull;
    // error marker only while a peer pulls the line, peer_pull high
    assign grp_err = peer_pull & peer_err;
endmodule
`default_nettype wire

// ===== test/tb_top.sv
// self-checking bench of the point-of-load fault manager
// assumes the hiccup interval shortened to HC cycles
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import power_fault_pkg::*;
    // *****************
    // signals
    // *****************
    localparam int unsigned HC = 50;
    logic clk_sys = 0;
    logic reset_n = 0;
    meas_type meas = '0;
    logic [7:0] temp_c = 8'h19;
    logic [7:0] pct = 8'h6E;
    logic oc_hit = 0, turn_on = 0, ramp_done = 0, track_dis = 0;
    logic peer_pull = 0, peer_err = 0;
    logic prop_en = 1;
    prot_flags_type prot_cfg = '0, clr = '0;
    wire grp_line, grp_err;
    logic ok_out, ok_oe_n;
    switch_ctrl_type sw;
    prot_flags_type flags;
    cause_type cause;
    int bad_count = 0, checked = 0, cyc = 0;

    power_fault_manager #(.HICCUP_CYCLES(HC)) u_power_fault_manager (
        .clk_sys(clk_sys), .reset_n(reset_n), .meas(meas), .temp_c(temp_c),
        .overvolt_pct(pct), .oc_limit_hit(oc_hit), .turn_on_cmd(turn_on),
        .ramp_complete(ramp_done), .protection_type_config(prot_cfg),
        .track_protect_disable(track_dis), .propagation_config(prop_en),
        .status_clear(clr), .group_ok_in(grp_line), .group_err_in(grp_err),
        .group_ok_out(ok_out), .group_ok_oe_n(ok_oe_n), .sw(sw),
        .protection_status_reg(flags), .shutdown_cause(cause));
    group_line_model u_group_line_model (.unit_out(ok_out),
        .unit_oe_n(ok_oe_n), .peer_pull(peer_pull), .peer_err(peer_err),
        .grp_line(grp_line), .grp_err(grp_err));

    always #10 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            final_report();
        end
    end
    // *****************
    // tasks
    // *****************
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #2;
    endtask
    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wait_cause();
        for (int i = 0; i < 30 && cause === CAUSE_NONE; i++) step(1);
    endtask
    task automatic power_on(input logic [15:0] vset, input logic [7:0] p);
        reset_n = 0;
        {turn_on, oc_hit, peer_pull, peer_err, track_dis} = '0;
        temp_c = 8'h19;
        pct = p;
        meas = {16'h0000, vset, 16'h0000, vset - 16'h0064};
        step(3);
        reset_n = 1;
        step(1);
        turn_on = 1;
        for (int i = 0; i < 20 && sw.ramp_up !== 1'h1; i++) step(1);
    endtask
    task automatic reach_steady(input logic [15:0] vset);
        meas.vout = vset;
        meas.target = vset;
        ramp_done = 1;
        step(2);
        ramp_done = 0;
        step(2);
    endtask
    task automatic trip(input logic [15:0] vset, vout, input logic oc,
        input logic [7:0] tc, p, input logic pp, pe, input cause_type ec,
        input logic [3:0] esw, msk, input prot_flags_type ef);
        power_on(vset, p);
        meas.vout = vset >> 1;
        meas.target = vset >> 1;
        step(4);
        chk("ramp cause", 8'h00, 8'(cause));
        reach_steady(vset);
        meas.vout = vout;
        {oc_hit, temp_c, peer_pull, peer_err} = {oc, tc, pp, pe};
        wait_cause();
        chk("cause", 8'(ec), 8'(cause));
        step(4);
        chk("switches", 8'(esw), 8'(sw & msk));
        chk("flags", 8'(ef), 8'(flags));
        if (ec != CAUSE_NONE && !pp) begin
            chk("pull", 8'h00, 8'(ok_oe_n));
            chk("line", 8'h00, 8'(grp_line));
        end
    endtask
    task automatic t_track(input logic [15:0] diff, input logic dis,
                           input cause_type ec, input prot_flags_type ef);
        power_on(16'h03E8, 8'h6E);
        track_dis = dis;
        meas.target = 16'h01F4;
        meas.vout = 16'h01F4 + diff;
        wait_cause();
        chk("track cause", 8'(ec), 8'(cause));
        step(2);
        chk("track flags", 8'(ef), 8'(flags));
        if (ec != CAUSE_NONE) chk("fast off", 8'h00, 8'(sw & 4'h9));
    endtask
    task automatic t_hiccup();
        int n;
        n = 0;
        trip(16'h03E8, 16'h0320, 0, 8'h19, 8'h6E, 0, 0, CAUSE_UNDERVOLT,
             4'h2, 4'h3, 5'h1E);
        meas.vout = 16'h0005;
        while (sw.ramp_up !== 1'h1 && n < 300) begin
            step(1);
            n++;
        end
        chk("interval", 8'h01, 8'(n >= HC && n <= HC + 3));
        chk("restart", 8'h01, 8'(sw.ramp_up));
        reach_steady(16'h03E8);
        chk("restored", 8'h1F, 8'(flags));
    endtask
    task automatic t_temp();
        trip(16'h03E8, 16'h03E8, 0, 8'h79, 8'h6E, 0, 0, CAUSE_OVERTEMP,
             4'h2, 4'h3, 5'h1D);
        meas.vout = 16'h0005;
        temp_c = 8'h6E;
        step(3);
        chk("warm hold", 8'h00, 8'(sw.ramp_up));
        temp_c = 8'h6D;
        step(1);
        chk("cool restart", 8'h01, 8'(sw.ramp_up));
    endtask
    task automatic t_latch();
        trip(16'h03E8, 16'h0320, 0, 8'h19, 8'h6E, 0, 0, CAUSE_UNDERVOLT,
             4'h2, 4'h3, 5'h1E);
        prot_cfg = 5'h01;
        prop_en = 0;
        meas.vout = 16'h0005;
        step(HC + 8);
        chk("latched", 8'h00, 8'(sw.ramp_up));
        chk("held flag", 8'h1E, 8'(flags));
        chk("no pull", 8'h01, 8'(ok_oe_n));
        prop_en = 1;
        clr = 5'h01;
        step(1);
        clr = 5'h00;
        step(1);
        chk("unlatched", 8'h01, 8'(sw.ramp_up));
        prot_cfg = 5'h00;
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // *****************
    // sequence
    // *****************
    initial begin
        step(3);
        reset_n = 1;
        step(1);
        chk("reset flags", 8'h1F, 8'(flags));
        chk("reset sw", 8'h00, 8'(sw));
        chk("reset pull", 8'h01, 8'(ok_oe_n));
        t_track(16'h00FA, 0, CAUSE_NONE, 5'h1F);
        t_track(16'h00FB, 0, CAUSE_TRACK, 5'h17);
        t_track(16'h0190, 1, CAUSE_NONE, 5'h1F);
        trip(16'h03E8, 16'h0320, 1, 8'h19, 8'h6E, 0, 0, CAUSE_OVERCUR,
             4'h0, 4'h9, 5'h1B);
        trip(16'h03E8, 16'h03E8, 0, 8'h79, 8'h6E, 0, 0, CAUSE_OVERTEMP,
             4'h2, 4'h3, 5'h1D);
        trip(16'h03E8, 16'h03E8, 0, 8'h78, 8'h6E, 0, 0, CAUSE_NONE,
             4'h8, 4'hF, 5'h1F);
        trip(16'h03E8, 16'h044D, 0, 8'h19, 8'h6E, 0, 0, CAUSE_OVERVOLT,
             4'h1, 4'h9, 5'h0F);
        trip(16'h03E8, 16'h044C, 0, 8'h19, 8'h64, 0, 0, CAUSE_NONE,
             4'h8, 4'hF, 5'h1F);
        trip(16'h03E8, 16'h0514, 0, 8'h19, 8'h8C, 0, 0, CAUSE_NONE,
             4'h8, 4'hF, 5'h1F);
        trip(16'h0320, 16'h03E7, 0, 8'h19, 8'h6E, 0, 0, CAUSE_NONE,
             4'h8, 4'hF, 5'h1F);
        trip(16'h0320, 16'h03E9, 0, 8'h19, 8'h6E, 0, 0, CAUSE_OVERVOLT,
             4'h1, 4'h9, 5'h0F);
        trip(16'h03E8, 16'h03E8, 0, 8'h19, 8'h6E, 1, 0, CAUSE_GROUP_FAULT,
             4'h2, 4'h3, 5'h1F);
        trip(16'h03E8, 16'h03E8, 0, 8'h19, 8'h6E, 1, 1, CAUSE_GROUP_ERROR,
             4'h0, 4'h9, 5'h1F);
        t_temp();
        t_latch();
        t_hiccup();
        final_report();
    end
endmodule
`default_nettype wire
